// [verilog/spi_cmd_pkg.sv]
// Constants and types shared by the SPI register command port
package spi_cmd_pkg;

   // Frame format
   localparam int         WORD_BITS    = 16;
   localparam logic [4:0] FRAME_PULSES = 5'h10;
   localparam logic [4:0] PULSE_MAX    = 5'h1F;
   localparam logic [4:0] PULSE_FIRST  = 5'h01;
   localparam logic [3:0] BIT_LAST     = 4'hF;
   localparam logic [3:0] BIT_STEP     = 4'h1;

   // Command word fields
   localparam int CMD_HI  = 15;
   localparam int CMD_LO  = 12;
   localparam int ADDR_HI = 11;
   localparam int ADDR_LO = 8;
   localparam int DATA_HI = 7;
   localparam int FLIP_HI = 14;
   localparam int ECHO_HI = 11;
   localparam logic [2:0] CHECK_FLIP = 3'h7;
   localparam logic       CHECK_TOP  = 1'h0;

   typedef enum logic [3:0] {
      CMD_CHECK      = 4'h0,
      CMD_RD_CFG     = 4'h1,
      CMD_WR_CFG     = 4'h2,
      CMD_RD_STS     = 4'h3,
      CMD_WR_STS     = 4'h4,
      CMD_RD_CTL     = 4'h5,
      CMD_WR_CTL     = 4'h6,
      CMD_CHECK_RESP = 4'h7
   } cmd_type;

   // Register banks: four 8-bit registers each
   localparam int         NUM_REGS     = 4;
   localparam logic [3:0] REG_ADDR_MAX = 4'h3;
   localparam logic [7:0] REG_RESET    = 8'h00;
   localparam logic [15:0] RESP_RESET  = 16'h0000;

   // Implemented bits per register, register 3 leftmost
   localparam logic [3:0][7:0] CFG_MASK  = {8'hDF, 8'h9F, 8'h9F, 8'h9F};
   localparam logic [3:0][7:0] CTL_MASK  = {8'hFF, 8'hFF, 8'hFF, 8'hFF};
   localparam logic [3:0][7:0] STS_MASK  = {8'hFF, 8'hFF, 8'hFF, 8'hF7};
   // Status bits that follow a live condition rather than latch a fault
   localparam logic [3:0][7:0] COND_MASK = {8'h00, 8'h00, 8'h70, 8'hF0};

   // Special bits
   localparam logic [1:0] ERR_REG = 2'h1;
   localparam int         ERR_BIT = 3;
   localparam logic [1:0] STE_REG = 2'h3;
   localparam int         STE_BIT = 0;

endpackage

// [verilog/spi_cmd_port.sv]
// SPI slave command port giving a host access to three register banks
`timescale 1ns/1ps
`default_nettype none

module spi_cmd_port (
   // System clock and reset
   input  wire logic        CLK_I,
   input  wire logic        ARST_N_I,
   // Serial link
   input  wire logic        SCLK_I,
   input  wire logic        CHIP_SELECT_N_I,
   input  wire logic        SERIAL_IN_I,
   output logic             SERIAL_OUT_O,
   output logic             SERIAL_OUT_OE_O,
   // Register contents
   output logic [31:0]      CONFIG_O,
   output logic [31:0]      CONTROL_O,
   output logic [31:0]      STATUS_O,
   output logic             SELF_TEST_WRITE_ENABLE_O,
   // Device conditions
   input  wire logic [31:0] FAULT_SET_I,
   input  wire logic [31:0] CONDITION_I
);

   typedef struct packed {
      logic            tog;
      logic [4:0]      cnt;
      logic [15:0]     shift;
   } link_type;

   typedef struct packed {
      logic [2:0]      cs_sync;
      logic [1:0]      tog_sync;
      logic            tog_snap;
      logic [3:0][7:0] cfg;
      logic [3:0][7:0] ctl;
      logic [3:0][7:0] sts;
      logic [15:0]     resp;
   } sys_type;

   link_type  ln_q;
   link_type  ln_d;
   sys_type   q;
   sys_type   d;
   logic      first_q;
   logic [3:0] idx_q;
   logic      frame_idle;

   logic      cs_rise;
   logic      had_pulses;
   logic      frame_ok;
   logic      cmd_ok;
   logic      do_exec;
   logic      do_reject;
   logic      ste;
   logic [15:0] word;
   logic [3:0]  cmd;
   logic [3:0]  addr;
   logic [1:0]  ra;
   logic [7:0]  data;

   // Link clock domain: rising edge side
   // Chip select high or reset re-arms the frame-start marker. The
   // pulse count is not cleared by it, so it survives until the
   // system side reads it after the frame.
   assign frame_idle = CHIP_SELECT_N_I | ~ARST_N_I;

   always_ff @(posedge SCLK_I or posedge frame_idle) begin
      if (frame_idle) begin
         first_q <= 1'b1;
      end else begin
         first_q <= 1'b0;
      end
   end

   always_comb begin
      ln_d = ln_q;
      if (!CHIP_SELECT_N_I) begin
         ln_d.shift = {ln_q.shift[14:0], SERIAL_IN_I};
         if (first_q) begin
            ln_d.cnt = spi_cmd_pkg::PULSE_FIRST;
            ln_d.tog = ~ln_q.tog;
         end else if (ln_q.cnt != spi_cmd_pkg::PULSE_MAX) begin
            ln_d.cnt = ln_q.cnt + spi_cmd_pkg::PULSE_FIRST;
         end
      end
   end

   always_ff @(posedge SCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         ln_q <= '0;
      end else begin
         ln_q <= ln_d;
      end
   end

   // Link clock domain: falling edge side
   always_ff @(negedge SCLK_I or posedge frame_idle) begin
      if (frame_idle) begin
         idx_q <= '0;
      end else if (idx_q != spi_cmd_pkg::BIT_LAST) begin
         idx_q <= idx_q + spi_cmd_pkg::BIT_STEP;
      end
   end

   // The answer word is only rewritten just after chip select rises,
   // so it is static for the whole of the next frame.
   assign SERIAL_OUT_O    =
      q.resp[spi_cmd_pkg::BIT_LAST - idx_q];
   assign SERIAL_OUT_OE_O = ~CHIP_SELECT_N_I;

   // System clock domain
   // Chip select pulses shorter than two system clocks may go unseen
   assign cs_rise    = q.cs_sync[1] & ~q.cs_sync[2];
   assign had_pulses = q.tog_sync[1] != q.tog_snap;
   // Word and count are read across domains only after chip select has
   // been high for two clocks, when no serial edges may occur.
   assign word       = ln_q.shift;
   assign cmd        = word[spi_cmd_pkg::CMD_HI:spi_cmd_pkg::CMD_LO];
   assign addr       = word[spi_cmd_pkg::ADDR_HI:spi_cmd_pkg::ADDR_LO];
   assign ra         = addr[1:0];
   assign data       = word[spi_cmd_pkg::DATA_HI:0];
   assign frame_ok   = had_pulses &
                       (ln_q.cnt == spi_cmd_pkg::FRAME_PULSES);
   assign cmd_ok     = (cmd == spi_cmd_pkg::CMD_CHECK) |
                       ((cmd >= spi_cmd_pkg::CMD_RD_CFG) &
                        (cmd <= spi_cmd_pkg::CMD_WR_CTL) &
                        (addr <= spi_cmd_pkg::REG_ADDR_MAX));
   assign do_exec    = cs_rise & frame_ok & cmd_ok;
   assign do_reject  = cs_rise & ~(frame_ok & cmd_ok);
   assign ste        = q.ctl[spi_cmd_pkg::STE_REG][spi_cmd_pkg::STE_BIT];

   always_comb begin
      d = q;
      d.cs_sync  = {q.cs_sync[1:0], CHIP_SELECT_N_I};
      d.tog_sync = {q.tog_sync[0], ln_q.tog};
      if (cs_rise) begin
         d.tog_snap = q.tog_sync[1];
      end
      // Condition bits track their inputs while reporting is live
      if (!ste) begin
         for (int i = 0; i < spi_cmd_pkg::NUM_REGS; i++) begin
            d.sts[i] = (q.sts[i] & ~spi_cmd_pkg::COND_MASK[i]) |
                       (CONDITION_I[i*8 +: 8] &
                        spi_cmd_pkg::COND_MASK[i]);
         end
      end
      if (do_exec) begin
         case (cmd)
            spi_cmd_pkg::CMD_CHECK: begin
               d.resp = {spi_cmd_pkg::CHECK_TOP,
                         word[spi_cmd_pkg::FLIP_HI:spi_cmd_pkg::CMD_LO] ^
                         spi_cmd_pkg::CHECK_FLIP,
                         word[spi_cmd_pkg::ECHO_HI:0]};
            end
            spi_cmd_pkg::CMD_RD_CFG: begin
               d.resp = {cmd, addr, q.cfg[ra]};
            end
            spi_cmd_pkg::CMD_RD_STS: begin
               d.resp = {cmd, addr, q.sts[ra]};
            end
            spi_cmd_pkg::CMD_RD_CTL: begin
               d.resp = {cmd, addr, q.ctl[ra]};
            end
            spi_cmd_pkg::CMD_WR_CFG: begin
               d.cfg[ra] = data & spi_cmd_pkg::CFG_MASK[ra];
               d.resp    = word;
            end
            spi_cmd_pkg::CMD_WR_CTL: begin
               d.ctl[ra] = data & spi_cmd_pkg::CTL_MASK[ra];
               d.resp    = word;
            end
            spi_cmd_pkg::CMD_WR_STS: begin
               if (ste) begin
                  d.sts[ra] = data & spi_cmd_pkg::STS_MASK[ra];
               end else begin
                  d.sts[ra] = d.sts[ra] & data;
               end
               d.resp = word;
            end
            default: begin
               d.resp = q.resp;
            end
         endcase
      end
      // Fault latching after the host write, so a set beats a clear
      if (!ste) begin
         for (int i = 0; i < spi_cmd_pkg::NUM_REGS; i++) begin
            d.sts[i] = d.sts[i] | (FAULT_SET_I[i*8 +: 8] &
                                   ~spi_cmd_pkg::COND_MASK[i]);
         end
      end
      if (do_reject) begin
         d.sts[spi_cmd_pkg::ERR_REG][spi_cmd_pkg::ERR_BIT] = 1'b1;
      end
      d.sts = d.sts & spi_cmd_pkg::STS_MASK;
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         q.cs_sync  <= '1;
         q.tog_sync <= '0;
         q.tog_snap <= 1'b0;
         q.cfg      <= {spi_cmd_pkg::NUM_REGS{spi_cmd_pkg::REG_RESET}};
         q.ctl      <= {spi_cmd_pkg::NUM_REGS{spi_cmd_pkg::REG_RESET}};
         q.sts      <= {spi_cmd_pkg::NUM_REGS{spi_cmd_pkg::REG_RESET}};
         q.resp     <= spi_cmd_pkg::RESP_RESET;
      end else begin
         q <= d;
      end
   end

   assign CONFIG_O                 = q.cfg;
   assign CONTROL_O                = q.ctl;
   assign STATUS_O                 = q.sts;
   // Reporting stays frozen until the host clears this bit again
   assign SELF_TEST_WRITE_ENABLE_O = ste;

   // Checks
   out_hiz_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      CHIP_SELECT_N_I |-> !SERIAL_OUT_OE_O)
      else $error("serial output driven while deselected");

   check_echo_a: assert property (@(posedge CLK_I)
      disable iff (!ARST_N_I)
      do_exec && cmd == spi_cmd_pkg::CMD_CHECK |=>
      q.resp == {4'h7, $past(word[11:0])})
      else $error("check answer wrong");

   count_err_a: assert property (@(posedge CLK_I)
      disable iff (!ARST_N_I)
      cs_rise && ln_q.cnt != 5'h10 |=> q.sts[1][3] && $stable(q.cfg))
      else $error("bad pulse count not flagged");

   bad_cmd_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      cs_rise && frame_ok && cmd > 4'h6 |=> q.sts[1][3])
      else $error("undefined command not flagged");

   unimpl_zero_a: assert property (@(posedge CLK_I)
      disable iff (!ARST_N_I)
      (q.sts & ~spi_cmd_pkg::STS_MASK) == '0 &&
      (q.cfg & ~spi_cmd_pkg::CFG_MASK) == '0)
      else $error("unimplemented bit set");

   reject_keep_a: assert property (@(posedge CLK_I)
      disable iff (!ARST_N_I)
      do_reject |=> $stable(q.cfg) && $stable(q.ctl) && $stable(q.resp))
      else $error("rejected frame changed registers");

   clear_only_a: assert property (@(posedge CLK_I)
      disable iff (!ARST_N_I)
      !ste && FAULT_SET_I == '0 && !do_reject |=>
      (q.sts & ~$past(q.sts) & ~spi_cmd_pkg::COND_MASK) == '0)
      else $error("status bit rose without a fault");

   freeze_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      ste && !cs_rise |=> $stable(q.sts))
      else $error("status changed while self-test enabled");

   write_cfg_a: assert property (@(posedge CLK_I)
      disable iff (!ARST_N_I)
      do_exec && cmd == spi_cmd_pkg::CMD_WR_CFG |=>
      q.cfg[$past(ra)] == ($past(data) & spi_cmd_pkg::CFG_MASK[$past(ra)]))
      else $error("configuration write not stored");

   read_ctl_a: assert property (@(posedge CLK_I)
      disable iff (!ARST_N_I)
      do_exec && cmd == spi_cmd_pkg::CMD_RD_CTL |=>
      q.resp == {$past(word[15:8]), $past(q.ctl[ra])})
      else $error("control read answer wrong");

   first_bit_a: assert property (@(posedge SCLK_I)
      disable iff (CHIP_SELECT_N_I)
      first_q |-> SERIAL_OUT_O == q.resp[15])
      else $error("first output bit not the answer MSB");

endmodule

`default_nettype wire

// [test/spi_host_model.sv]
// Host side of the serial link: a master that runs one frame per call
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
   // Serial link
   output logic      sclk_o,
   output logic      cs_n_o, // One select per device, no daisy chain
   output logic      mosi_o,
   input  wire logic miso_i,
   input  wire logic miso_oe_i
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end

   // Clock stands low between frames; 6 ns period while a frame runs
   task automatic xfer(input logic [15:0] tx, input int n,
                       output logic [15:0] rx);
      rx = 16'h0000;
      cs_n_o = 1'b0; // Chip select moves only with the clock low
      for (int i = 0; i < n; i++) begin
         mosi_o = tx[15 - (i % 16)]; // Most significant bit first
         #3;
         rx = {rx[14:0], miso_oe_i ? miso_i : 1'bx}; // Sample on rise
         sclk_o = 1'b1;
         #3;
         sclk_o = 1'b0;
      end
      #3;
      // A frame without pulses must still be seen by the system clock
      if (n == 0) #60;
      cs_n_o = 1'b1;
      // Released line shows no stale bit
      mosi_o = ~mosi_o;
   endtask
endmodule

`default_nettype wire

// [test/spi_cmd_port_tb_top.sv]
// Self-checking bench for the SPI register command port
`timescale 1ns/1ps
`default_nettype none

module spi_cmd_port_tb_top;
   logic        clk, arst_n, sclk, cs_n, si, so, so_oe, ste;
   logic [31:0] cfg, ctl, sts, fault, cond;
   logic [15:0] rx;
   logic [15:0] bad_w [5] = '{16'h2200, 16'h7000, 16'h2400, 16'h2200,
                              16'h2200};
   int          bad_n [5] = '{15, 16, 16, 17, 0};
   int          err_count = 0;
   int          checks = 0;

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   spi_cmd_port dut_u (
      .CLK_I(clk), .ARST_N_I(arst_n), .SCLK_I(sclk),
      .CHIP_SELECT_N_I(cs_n), .SERIAL_IN_I(si), .SERIAL_OUT_O(so),
      .SERIAL_OUT_OE_O(so_oe), .CONFIG_O(cfg), .CONTROL_O(ctl),
      .STATUS_O(sts), .SELF_TEST_WRITE_ENABLE_O(ste),
      .FAULT_SET_I(fault), .CONDITION_I(cond));

   spi_host_model host_u (
      .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(si), .miso_i(so),
      .miso_oe_i(so_oe));

   task automatic test_done();
      if (err_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Gap after each frame covers the chip select minimum and the update
   task automatic frame(input logic [15:0] tx, input int n = 16);
      @(posedge clk);
      #1.7;
      chk(so_oe, 1'b0);
      host_u.xfer(tx, n, rx);
      repeat (10) @(posedge clk);
   endtask

   task automatic pulse_fault();
      @(posedge clk) fault <= 32'h1;
      @(posedge clk) fault <= 32'h0;
      repeat (2) @(posedge clk);
   endtask

   initial begin
      #50000;
      err_count++;
      test_done();
   end

   initial begin
      arst_n = 1'b0;
      fault = 32'h0;
      cond = 32'h0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk({cfg | ctl | sts}, 32'h0);
      frame(16'h22FF);
      chk(cfg[23:16], 8'h9F);
      frame(16'h0ABC);
      chk(rx, 16'h22FF);
      frame(16'h61A5);
      chk(rx, 16'h7ABC);
      chk(ctl[15:8], 8'hA5);
      frame(16'h5100);
      frame(16'h1200);
      chk(rx, 16'h51A5);
      for (int k = 0; k < 5; k++) begin
         frame(bad_w[k], bad_n[k]);
         chk(sts[11], 1'b1);
         chk(cfg[23:16], 8'h9F);
         frame(16'h4100);
         chk(rx, (k == 0) ? 16'h129F : 16'h4100);
         chk(sts[11], 1'b0);
      end
      frame(16'h3100);
      chk(rx, 16'h4100);
      frame(16'h0000);
      chk(rx, 16'h3100);
      pulse_fault();
      chk(sts[7:0], 8'h01);
      frame(16'h40FF);
      chk(sts[7:0], 8'h01);
      frame(16'h40FE);
      chk(sts[7:0], 8'h00);
      frame(16'h6301);
      chk(ste, 1'b1);
      frame(16'h40FF);
      chk(sts[7:0], 8'hF7);
      frame(16'h4000);
      pulse_fault();
      chk(sts[7:0], 8'h00);
      frame(16'h6300); // Clear self-test before resuming
      chk(ste, 1'b0);
      pulse_fault();
      chk(sts[7:0], 8'h01);
      @(posedge clk) cond <= 32'h10;
      repeat (4) @(posedge clk);
      chk(sts[7:0], 8'h11);
      @(posedge clk) cond <= 32'h0;
      repeat (4) @(posedge clk);
      chk(sts[7:0], 8'h01);
      test_done();
   end
endmodule

`default_nettype wire
